// >>> core/irc_carrier.sv
// infrared carrier generator with apb register slave
// Summary of operation
// RL1 - the carrier pin is held low during reset and right after it.
// RL2 - the pin source is a build-time parameter, fixed or timer, never changed at run time.
// RL3 - the fixed carrier starts at 38kHz one-third duty after reset.
// RL4 - two select bits choose 38kHz 1/3, 38kHz 1/2 or 57kHz 1/2 duty.
// RL5 - in timer mode an 8-bit counter reloaded from a loaded setting at each overflow makes the carrier.
// RL6 - a software enable bit gates the carrier onto the pin in either mode.
// RL7 - the timer mode at a 455kHz base spans about 0.9kHz to 228kHz.
// RL8 - select code 00 is 38kHz 1/3, 01 is 38kHz 1/2, 10 is 57kHz 1/2, 11 acts as 00.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module irc_carrier
   import irc_pkg::*;
#(
   parameter irc_pkg::irc_src_t SOURCE = irc_pkg::IRC_SRC_FIXED,
   parameter int SYS_DIV = irc_pkg::IRC_SYS_DIV,
   parameter int P38 = irc_pkg::IRC_P38,
   parameter int P57 = irc_pkg::IRC_P57
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // carrier pin
   output logic carrier_out_pin
);
   import irc_pkg::*;

   localparam int CW = 20;
   localparam logic [CW-1:0] C38 = CW'(P38 - 1);
   localparam logic [CW-1:0] C57 = CW'(P57 - 1);
   localparam logic [CW-1:0] T38 = CW'(P38 / 3);
   localparam logic [CW-1:0] H38 = CW'(P38 / 2);
   localparam logic [CW-1:0] H57 = CW'(P57 / 2);
   localparam logic [9:0] SDIV = 10'(SYS_DIV - 1);

   // control register state
   logic carrier_enable_flag, next_enable;
   logic carrier_select_hi, next_sel_hi;
   logic carrier_select_lo, next_sel_lo;
   logic [7:0] tmr_setting, next_tmr_setting;
   logic [31:0] next_prdata;

   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite;
   wire logic hit = paddr == IRC_CTRL_ADDR || paddr == IRC_TMR_ADDR
      || paddr == IRC_STAT_ADDR;

   // carrier generator state
   logic [CW-1:0] fcnt, next_fcnt;
   logic [9:0] sdiv, next_sdiv;
   logic [7:0] tcnt, next_tcnt;
   logic tgl, next_tgl;
   logic carrier_raw;
   logic next_pin;

   // zero-wait slave: answer in the access cycle
   assign pready = 1'b1;
   // unmapped offsets answer with an error and the write is dropped
   assign pslverr = acc && !hit;

   always_comb begin
      next_enable = carrier_enable_flag;
      next_sel_hi = carrier_select_hi;
      next_sel_lo = carrier_select_lo;
      next_tmr_setting = tmr_setting;
      next_prdata = prdata;
      if (wr && paddr == IRC_CTRL_ADDR) begin
         next_enable = pwdata[IRC_EN_BIT]; // see RL6
         next_sel_lo = pwdata[IRC_SEL_LO_BIT]; // see RL4
         next_sel_hi = pwdata[IRC_SEL_HI_BIT];
      end
      if (wr && paddr == IRC_TMR_ADDR) begin
         next_tmr_setting = pwdata[7:0]; // see RL5
      end
      if (psel && !penable && !pwrite) begin
         next_prdata = 32'h0;
         case (paddr)
            IRC_CTRL_ADDR: begin
               next_prdata[IRC_EN_BIT] = carrier_enable_flag;
               next_prdata[IRC_SEL_LO_BIT] = carrier_select_lo;
               next_prdata[IRC_SEL_HI_BIT] = carrier_select_hi;
            end
            IRC_TMR_ADDR: begin
               next_prdata[7:0] = tmr_setting;
            end
            IRC_STAT_ADDR: begin
               next_prdata[0] = carrier_out_pin;
               next_prdata[1] = SOURCE == IRC_SRC_TIMER;
               next_prdata[15:8] = tcnt;
            end
            default: begin
               next_prdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier_enable_flag <= 1'b0;
         carrier_select_hi <= IRC_SEL_RESET[1]; // see RL3
         carrier_select_lo <= IRC_SEL_RESET[0];
         tmr_setting <= IRC_TMR_RESET;
         prdata <= 32'h0;
      end else begin
         carrier_enable_flag <= next_enable;
         carrier_select_hi <= next_sel_hi;
         carrier_select_lo <= next_sel_lo;
         tmr_setting <= next_tmr_setting;
         prdata <= next_prdata;
      end
   end

   // select bits come out of reset at the default carrier
   sel_reset_a: assert property (@(posedge pclk) // see RL3
      $rose(presetn) |-> {carrier_select_hi, carrier_select_lo} == IRC_SEL_RESET)
      else $error("select bits not at default after reset");
   // a control write lands at the access edge
   ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
      wr && paddr == IRC_CTRL_ADDR |=> carrier_enable_flag == $past(pwdata[IRC_EN_BIT])
      && carrier_select_lo == $past(pwdata[IRC_SEL_LO_BIT])
      && carrier_select_hi == $past(pwdata[IRC_SEL_HI_BIT]))
      else $error("control write not stored");
   // the timer setting lands at the access edge
   tmr_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL5
      wr && paddr == IRC_TMR_ADDR |=> tmr_setting == $past(pwdata[7:0]))
      else $error("timer setting write not stored");

   // fixed and timer carrier sources
   always_comb begin
      logic [CW-1:0] per;
      logic [CW-1:0] hi;
      per = C38;
      hi = T38;
      case (irc_sel_t'({carrier_select_hi, carrier_select_lo}))
         IRC_SEL_38_HALF: begin
            per = C38; // see RL8
            hi = H38;
         end
         IRC_SEL_57_HALF: begin
            per = C57; // see RL4
            hi = H57;
         end
         default: begin
            per = C38; // see RL8
            hi = T38;
         end
      endcase
      // wrap counters; the casts drop the carry on purpose
      next_fcnt = (fcnt >= per) ? '0 : CW'(fcnt + 1'b1);
      next_sdiv = (sdiv == SDIV) ? '0 : 10'(sdiv + 1'b1);
      next_tcnt = tcnt;
      next_tgl = tgl;
      // 455kHz tick drives the 8-bit counter; overflow toggles a divide-by-2
      // tcnt free-runs while off, so the first half wave after enable is short
      if (sdiv == SDIV) begin
         if (tcnt == 8'hFF) begin
            next_tcnt = tmr_setting; // see RL5
            next_tgl = !tgl; // see RL7
         end else begin
            next_tcnt = 8'(tcnt + 8'h01);
         end
      end
      if (SOURCE == IRC_SRC_TIMER) begin
         carrier_raw = tgl; // see RL2
      end else begin
         carrier_raw = fcnt < hi;
      end
      // restart fcnt and tgl while off so the fixed waveform begins cleanly
      if (!carrier_enable_flag) begin
         next_fcnt = '0;
         next_tgl = 1'b0;
      end
      next_pin = carrier_enable_flag && carrier_raw; // see RL6
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fcnt <= '0;
         sdiv <= '0;
         tcnt <= '0;
         tgl <= 1'b0;
         carrier_out_pin <= 1'b0; // see RL1
      end else begin
         fcnt <= next_fcnt;
         sdiv <= next_sdiv;
         tcnt <= next_tcnt;
         tgl <= next_tgl;
         carrier_out_pin <= next_pin;
      end
   end

   // pin low whenever disabled, one cycle after the register says so
   pin_off_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
      !carrier_enable_flag |=> !carrier_out_pin)
      else $error("carrier pin high while disabled");
   // at the first clock after reset release the pin is low
   reset_low_a: assert property (@(posedge pclk) // see RL1
      $rose(presetn) |-> !carrier_out_pin)
      else $error("carrier pin not low after reset");

   // the fixed counter never runs past the longest period
   fcnt_bound_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
      (fcnt <= C38) || (fcnt <= C57))
      else $error("fixed carrier counter out of range");
   // 57kHz code: pin high while the count is below half the short period
   fast_code_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
      SOURCE == IRC_SRC_FIXED && carrier_enable_flag
      && irc_sel_t'({carrier_select_hi, carrier_select_lo}) == IRC_SEL_57_HALF
      |=> carrier_out_pin == ($past(fcnt) < H57))
      else $error("57kHz carrier shape wrong");
   // reserved code must shape the pin exactly like the default code
   rsvd_code_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
      SOURCE == IRC_SRC_FIXED && carrier_enable_flag
      && irc_sel_t'({carrier_select_hi, carrier_select_lo}) == IRC_SEL_RSVD
      |=> carrier_out_pin == ($past(fcnt) < T38))
      else $error("reserved code not shaped as default");
endmodule // irc_carrier
`default_nettype wire

// >>> core/irc_pkg.sv
// package for the infrared carrier generator: register map, fields, timing
package irc_pkg;
   // register byte addresses
   localparam logic [11:0] IRC_CTRL_ADDR = 12'h000;
   localparam logic [11:0] IRC_TMR_ADDR = 12'h004;
   localparam logic [11:0] IRC_STAT_ADDR = 12'h008;
   // control register fields
   localparam int IRC_EN_BIT = 0;
   localparam int IRC_SEL_LO_BIT = 1;
   localparam int IRC_SEL_HI_BIT = 2;
   localparam logic [1:0] IRC_SEL_RESET = 2'h0;
   localparam logic [7:0] IRC_TMR_RESET = 8'h00;
   // clocks in kHz
   localparam int IRC_PCLK_KHZ = 250000;
   localparam int IRC_SYS_KHZ = 455;
   localparam int IRC_F38_KHZ = 38;
   localparam int IRC_F57_KHZ = 57;
   // derived cycle counts
   localparam int IRC_SYS_DIV = IRC_PCLK_KHZ / IRC_SYS_KHZ;
   localparam int IRC_P38 = IRC_PCLK_KHZ / IRC_F38_KHZ;
   localparam int IRC_P57 = IRC_PCLK_KHZ / IRC_F57_KHZ;
   localparam int IRC_P38_THIRD = IRC_P38 / 3;
   localparam int IRC_P38_HALF = IRC_P38 / 2;
   localparam int IRC_P57_HALF = IRC_P57 / 2;
   typedef enum logic [1:0] {
      IRC_SEL_38_THIRD = 2'h0,
      IRC_SEL_38_HALF = 2'h1,
      IRC_SEL_57_HALF = 2'h2,
      IRC_SEL_RSVD = 2'h3
   } irc_sel_t;
   // build-time source choice
   typedef enum logic {
      IRC_SRC_FIXED = 1'b0,
      IRC_SRC_TIMER = 1'b1
   } irc_src_t;
endpackage

// >>> verification/irc_led_model.sv
// led driver stage model: measures carrier high time and period
`timescale 1ns/1ns
`default_nettype none
module irc_led_model (
   // clock
   input wire logic pclk,
   // carrier pin
   input wire logic carrier_out_pin,
   // last measured pulse
   output logic [15:0] hi_len,
   output logic [15:0] per_len,
   output logic seen
);
   logic [15:0] cnt;
   logic [15:0] hi_cnt;
   logic last;
   initial begin
      cnt = 16'h0000;
      hi_cnt = 16'h0000;
      last = 1'b0;
      seen = 1'b0;
      hi_len = 16'h0000;
      per_len = 16'h0000;
   end
   // a rising edge closes one period; the first one after enable is junk
   always @(posedge pclk) begin
      seen <= 1'b0;
      last <= carrier_out_pin;
      cnt <= cnt + 16'h0001;
      hi_cnt <= hi_cnt + {15'h0000, carrier_out_pin};
      if (carrier_out_pin && !last) begin
         hi_len <= hi_cnt;
         per_len <= cnt;
         seen <= 1'b1;
         cnt <= 16'h0001;
         hi_cnt <= 16'h0001;
      end
   end
endmodule // irc_led_model
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the infrared carrier generator
`timescale 1ns/1ns
`default_nettype none
module tb;
   import irc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, carrier_out_pin, seen, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [15:0] hi_len, per_len;
   logic [31:0] exp_q[$];
   // second build with the timer source, sharing the bus
   logic tmr_pin, tmr_seen;
   logic [31:0] tmr_prdata;
   logic [15:0] tmr_hi_len, tmr_per_len;
   logic [31:0] tmr_exp_q[$];
   int failures, compares;
   irc_carrier #(.SOURCE(IRC_SRC_FIXED), .SYS_DIV(2), .P38(12), .P57(8)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .carrier_out_pin(carrier_out_pin));
   irc_led_model u_led (.pclk(pclk), .carrier_out_pin(carrier_out_pin),
      .hi_len(hi_len), .per_len(per_len), .seen(seen));
   irc_carrier #(.SOURCE(IRC_SRC_TIMER), .SYS_DIV(2), .P38(12), .P57(8)) u_dut_tmr (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(tmr_prdata), .pready(), .pslverr(),
      .carrier_out_pin(tmr_pin));
   irc_led_model u_led_tmr (.pclk(pclk), .carrier_out_pin(tmr_pin),
      .hi_len(tmr_hi_len), .per_len(tmr_per_len), .seen(tmr_seen));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic give_verdict;
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // steady-state pulse shape is compared against the oldest note
   always @(posedge pclk) begin
      if (seen === 1'b1 && exp_q.size() > 0) check({hi_len, per_len}, exp_q.pop_front());
   end
   always @(posedge pclk) begin
      if (tmr_seen === 1'b1 && tmr_exp_q.size() > 0) begin
         check({tmr_hi_len, tmr_per_len}, tmr_exp_q.pop_front());
      end
   end
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (3000) @(posedge pclk);
      failures++;
      give_verdict();
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; seed = 32'd54663; failures = 0; compares = 0;
      repeat (6) @(posedge pclk);
      check({31'h0, carrier_out_pin}, 32'h0);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      check({31'h0, carrier_out_pin}, 32'h0);
      // s = -1 enables with reset select bits, then every code incl. reserved
      for (int s = -1; s < 4; s++) begin
         seed = xs(seed);
         apb(1'b1, IRC_CTRL_ADDR, (s < 0) ? 32'h1 : {seed[31:3], s[1:0], 1'b1});
         repeat (40) @(posedge pclk);
         exp_q.push_back({16'((s == 2 ? 8 : 12) / (s == 1 || s == 2 ? 2 : 3)),
            16'(s == 2 ? 8 : 12)});
         repeat (30) @(posedge pclk);
      end
      check(exp_q.size(), 32'h0);
      // reset again while the carrier runs: pin and control must clear
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      check({31'h0, carrier_out_pin}, 32'h0);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      check({31'h0, carrier_out_pin}, 32'h0);
      check({31'h0, tmr_pin}, 32'h0);
      apb(1'b0, IRC_CTRL_ADDR, 32'h0);
      check(rd, {29'h0, IRC_SEL_RESET, 1'b0});
      apb(1'b1, IRC_CTRL_ADDR, 32'h0);
      repeat (20) @(posedge pclk);
      check({31'h0, carrier_out_pin}, 32'h0);
      apb(1'b0, IRC_STAT_ADDR, 32'h0);
      check({30'h0, rd[1:0]}, 32'h0);
      check({30'h0, tmr_prdata[1:0]}, {30'h0, IRC_SRC_TIMER, 1'b0});
      apb(1'b1, IRC_TMR_ADDR, seed);
      apb(1'b0, IRC_TMR_ADDR, 32'h0);
      check({24'h0, rd[7:0]}, {24'h0, seed[7:0]});
      apb(1'b0, 12'h00C, 32'h0);
      check({err, rd[30:0]}, 32'h80000000);
      // timer build: reload near the top, half wave is 2 pclk per tick left
      seed = xs(seed);
      apb(1'b1, IRC_TMR_ADDR, {seed[31:8], 4'hF, seed[3:0]});
      apb(1'b1, IRC_CTRL_ADDR, 32'h1);
      repeat (600) @(posedge pclk);
      tmr_exp_q.push_back({16'(2 * (16 - seed[3:0])), 16'(4 * (16 - seed[3:0]))});
      repeat (80) @(posedge pclk);
      check(tmr_exp_q.size(), 32'h0);
      give_verdict();
   end
endmodule // tb
`default_nettype wire
